// file: hw/flash_host_ctrl.sv
// Host controller for a dual-bank parallel NOR flash, with an AHB-Lite register slave.
// Assumes pin inputs are synchronous to hclk and the flash answers within the read access count.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl #(
	parameter logic [19:0] UNLOCK1_ADDR    = 20'h00555,
	parameter logic [7:0]  UNLOCK1_DATA    = 8'hAA,
	parameter logic [19:0] UNLOCK2_ADDR    = 20'h002AA,
	parameter logic [7:0]  UNLOCK2_DATA    = 8'h55,
	parameter logic [7:0]  PROGRAM_CMD     = 8'hA0,
	parameter logic [7:0]  ERASE_SETUP_CMD = 8'h80
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	output var  logic [19:0] fl_addr,
	output var  logic        ce_n,
	output var  logic        we_n,
	output var  logic        oe_n,
	output var  logic        byte_n,
	output var  logic        wp_n,
	input  wire logic [15:0] dq_in,
	output var  logic [15:0] dq_out,
	output var  logic [15:0] dq_oe,
	input  wire logic        ready_busy_n
);
	logic           acc, wr_pend_q, go_q, sts_clr, busy;
	logic [7:0]     wr_off_q;
	logic [2:0]     go_op_q, op_q, step_q, nsteps;
	logic [20:0]    adr_q, tgt_q, eadr_q;
	logic [15:0]    wdata_q, rdata_q, rd, idle_oe;
	logic           wide_q, wp_rel_q, done_q, fail_q, refused_q;
	logic           done_set_q, fail_set_q, refuse_set_q;
	logic           polling_q, last_read_q, have_prev_q, prev_tog_q, susp_q, susp_blk_q;
	logic [1:0]     vcnt_q;
	logic [fh_pkg::TW-1:0] timer_q, wait_cnt_q;
	logic [31:0]    status_w;
	logic [36:0]    cw;
	logic           bad, take_idle, take_susp, erase_poll, in_susp, valid;
	fh_pkg::state_t state_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	assign acc     = hsel && htrans[1] && hready;
	assign sts_clr = wr_pend_q && wr_off_q == fh_pkg::REG_STATUS;
	assign busy    = state_q != fh_pkg::S_IDLE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_off_q  <= 8'h00;
			go_q      <= 1'b0;
			go_op_q   <= 3'h0;
			adr_q     <= 21'h000000;
			wdata_q   <= 16'h0000;
			{wp_rel_q, wide_q} <= fh_pkg::CFG_RESET;
			done_q    <= 1'b0;
			fail_q    <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			wr_pend_q <= acc && hwrite;
			if (acc)
				wr_off_q <= haddr[7:0];
			go_q <= wr_pend_q && wr_off_q == fh_pkg::REG_CTRL && hwdata[fh_pkg::CTRL_GO];
			if (wr_pend_q) begin
				case (wr_off_q)
					fh_pkg::REG_CTRL:   go_op_q <= hwdata[fh_pkg::CTRL_OP_LSB +: 3];
					fh_pkg::REG_ADDR:   adr_q <= hwdata[20:0];
					fh_pkg::REG_WDATA:  wdata_q <= hwdata[15:0];
					fh_pkg::REG_CONFIG: {wp_rel_q, wide_q} <= hwdata[1:0];
					default: ;
				endcase
			end
			// Write one to clear; a new event in the same cycle wins
			done_q    <= done_set_q | (done_q & ~(sts_clr & hwdata[fh_pkg::STS_DONE]));
			fail_q    <= fail_set_q | (fail_q & ~(sts_clr & hwdata[fh_pkg::STS_FAIL]));
			refused_q <= refuse_set_q | (refused_q & ~(sts_clr & hwdata[fh_pkg::STS_REFUSED]));
		end
	end

	always_comb begin
		status_w = 32'h00000000;
		status_w[fh_pkg::STS_BUSY]    = busy;
		status_w[fh_pkg::STS_DONE]    = done_q;
		status_w[fh_pkg::STS_FAIL]    = fail_q;
		status_w[fh_pkg::STS_REFUSED] = refused_q;
		status_w[fh_pkg::STS_SUSP]    = susp_q;
		status_w[fh_pkg::STS_RDY]     = ready_busy_n;
	end

	// Zero wait states: read data is chosen in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (acc && !hwrite) begin
			case (haddr[7:0])
				fh_pkg::REG_CTRL:   hrdata <= {25'h0000000, go_op_q, 4'h0};
				fh_pkg::REG_ADDR:   hrdata <= {11'h000, adr_q};
				fh_pkg::REG_WDATA:  hrdata <= {16'h0000, wdata_q};
				fh_pkg::REG_RDATA:  hrdata <= {16'h0000, rdata_q};
				fh_pkg::REG_STATUS: hrdata <= status_w;
				fh_pkg::REG_CONFIG: hrdata <= {30'h00000000, wp_rel_q, wide_q};
				default:            hrdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte_n <= 1'b1;
			wp_n   <= 1'b0;
		end else begin
			byte_n <= wide_q;
			wp_n   <= wp_rel_q;
		end
	end

	// One bus cycle's {word address, A-1, data} for the current op and step
	function automatic logic [36:0] cyc(input logic [2:0] op, input logic [2:0] step,
		input logic [20:0] a, input logic [15:0] d);
		logic [36:0] fin;
		logic [36:0] u1;
		logic [36:0] u2;
		u1 = {UNLOCK1_ADDR, 1'b0, 8'h00, UNLOCK1_DATA};
		u2 = {UNLOCK2_ADDR, 1'b0, 8'h00, UNLOCK2_DATA};
		case (op)
			fh_pkg::OP_PROGRAM: fin = {a[19:0], a[20], d};
			fh_pkg::OP_SECTOR:  fin = {a[19:0], a[20], 8'h00, fh_pkg::CMD_SECTOR};
			fh_pkg::OP_BLOCK:   fin = {a[19:0], a[20], 8'h00, fh_pkg::CMD_BLOCK};
			fh_pkg::OP_CHIP:    fin = {fh_pkg::CHIP_ADDR, 1'b0, 8'h00, fh_pkg::CMD_CHIP};
			fh_pkg::OP_SUSPEND: fin = {a[19:0], a[20], 8'h00, fh_pkg::CMD_SUSPEND};
			default:            fin = {a[19:0], a[20], 8'h00, fh_pkg::CMD_RESUME};
		endcase
		if (op == fh_pkg::OP_SUSPEND || op == fh_pkg::OP_RESUME)
			return fin;
		case (step)
			3'h0:    return u1;
			3'h1:    return u2;
			3'h2:    return {UNLOCK1_ADDR, 1'b0, 8'h00,
				(op == fh_pkg::OP_PROGRAM) ? PROGRAM_CMD : ERASE_SETUP_CMD};
			3'h3:    return (op == fh_pkg::OP_PROGRAM) ? fin : u1;
			3'h4:    return u2;
			default: return fin;
		endcase
	endfunction : cyc

	assign cw      = cyc(op_q, step_q, tgt_q, wdata_q);
	assign nsteps  = (op_q == fh_pkg::OP_PROGRAM) ? fh_pkg::PROG_STEPS :
		(op_q == fh_pkg::OP_SUSPEND || op_q == fh_pkg::OP_RESUME) ? 3'h1 :
		(op_q == fh_pkg::OP_READ) ? 3'h0 : fh_pkg::ERASE_STEPS;
	assign rd      = wide_q ? dq_in : {8'h00, dq_in[7:0]};
	assign idle_oe = wide_q ? 16'h0000 : fh_pkg::DQ_A1;
	assign in_susp = susp_blk_q ? adr_q[19:fh_pkg::BLOCK_LSB] == eadr_q[19:fh_pkg::BLOCK_LSB] :
		adr_q[19:fh_pkg::SECTOR_LSB] == eadr_q[19:fh_pkg::SECTOR_LSB];
	assign bad = go_op_q > fh_pkg::OP_RESUME || go_op_q == fh_pkg::OP_SUSPEND
		|| (go_op_q == fh_pkg::OP_CHIP && !wp_rel_q)
		|| (go_op_q == fh_pkg::OP_RESUME && !susp_q)
		|| (susp_q && go_op_q inside {fh_pkg::OP_SECTOR, fh_pkg::OP_BLOCK, fh_pkg::OP_CHIP})
		|| (susp_q && go_op_q == fh_pkg::OP_PROGRAM && in_susp);
	assign erase_poll = polling_q && op_q inside {fh_pkg::OP_SECTOR, fh_pkg::OP_BLOCK, fh_pkg::OP_RESUME};
	assign take_idle  = go_q && state_q == fh_pkg::S_IDLE && !bad;
	// Only a suspend may break into a running sector or block erase
	assign take_susp  = go_q && go_op_q == fh_pkg::OP_SUSPEND && erase_poll
		&& (state_q == fh_pkg::S_GAP || state_q == fh_pkg::S_READ);
	// Program: exact data back; erase: polling bit at one
	assign valid = (op_q == fh_pkg::OP_PROGRAM) ?
		(wide_q ? rdata_q == wdata_q : rdata_q[7:0] == wdata_q[7:0]) : rdata_q[7];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= fh_pkg::S_IDLE;
			{op_q, step_q, vcnt_q, timer_q} <= '0;
			{tgt_q, eadr_q, rdata_q} <= '0;
			{polling_q, last_read_q, have_prev_q, prev_tog_q, susp_q, susp_blk_q} <= 6'h00;
			{done_set_q, fail_set_q, refuse_set_q} <= 3'h0;
			{ce_n, we_n, oe_n} <= 3'h7;
			fl_addr <= 20'h00000;
			dq_out  <= 16'h0000;
			dq_oe   <= 16'h0000;
		end else begin
			done_set_q   <= 1'b0;
			fail_set_q   <= 1'b0;
			refuse_set_q <= go_q && !take_idle && !take_susp;
			case (state_q)
				fh_pkg::S_IDLE: begin
					dq_oe <= idle_oe;
					if (take_idle) begin
						op_q <= go_op_q;
						{step_q, vcnt_q} <= '0;
						{polling_q, last_read_q, have_prev_q} <= 3'h0;
						tgt_q <= (go_op_q == fh_pkg::OP_RESUME) ? eadr_q : adr_q;
						state_q <= fh_pkg::S_GAP;
						if (go_op_q == fh_pkg::OP_SECTOR || go_op_q == fh_pkg::OP_BLOCK) begin
							eadr_q     <= adr_q;
							susp_blk_q <= go_op_q == fh_pkg::OP_BLOCK;
						end
						if (go_op_q == fh_pkg::OP_RESUME)
							susp_q <= 1'b0;
						if (go_op_q == fh_pkg::OP_READ)
							issue_read(adr_q);
					end
				end
				fh_pkg::S_GAP: begin
					if (take_susp) begin
						op_q <= fh_pkg::OP_SUSPEND;
						{step_q, polling_q, last_read_q} <= '0;
					end else if (last_read_q && polling_q) begin
						if (!have_prev_q || rdata_q[6] != prev_tog_q) begin
							have_prev_q <= 1'b1;
							prev_tog_q  <= rdata_q[6];
							issue_read(tgt_q);
						end else if (valid) begin
							finish(1'b0);
						end else if (vcnt_q != 2'h2) begin
							vcnt_q <= vcnt_q + 2'h1;
							issue_read(tgt_q);
						end else begin
							finish(1'b1);
						end
					end else if (last_read_q) begin
						finish(1'b0);
					end else if (step_q < nsteps) begin
						// Word address sits above the A-1 bit; x8 puts A-1 on the top data line
						fl_addr <= cw[36:17];
						dq_out  <= wide_q ? cw[15:0] : {cw[16], 7'h00, cw[7:0]};
						dq_oe   <= wide_q ? fh_pkg::DQ_ALL : fh_pkg::DQ_LOW_A1;
						ce_n    <= 1'b0;
						timer_q <= fh_pkg::SETUP_CYC - 1'b1;
						state_q <= fh_pkg::S_SETUP;
					end else if (op_q == fh_pkg::OP_SUSPEND) begin
						timer_q <= fh_pkg::SUSPEND_LATENCY_CYC - 1'b1;
						state_q <= fh_pkg::S_SUSP_WAIT;
					end else begin
						polling_q <= 1'b1;
						issue_read(tgt_q);
					end
				end
				fh_pkg::S_SETUP: begin
					timer_q <= timer_q - 1'b1;
					if (timer_q == '0) begin
						we_n    <= 1'b0;
						timer_q <= fh_pkg::WE_CYC - 1'b1;
						state_q <= fh_pkg::S_STROBE;
					end
				end
				fh_pkg::S_STROBE: begin
					timer_q <= timer_q - 1'b1;
					if (timer_q == '0) begin
						we_n    <= 1'b1;
						state_q <= fh_pkg::S_HOLD;
					end
				end
				fh_pkg::S_HOLD: begin
					// Data and ce held one cycle past the strobe rise
					{ce_n, oe_n} <= 2'h3;
					dq_oe   <= idle_oe;
					step_q  <= step_q + 3'h1;
					state_q <= fh_pkg::S_GAP;
				end
				fh_pkg::S_READ: begin
					timer_q <= timer_q - 1'b1;
					if (take_susp || timer_q == '0) begin
						{ce_n, oe_n} <= 2'h3;
						state_q <= fh_pkg::S_GAP;
						last_read_q <= !take_susp;
						if (!take_susp)
							rdata_q <= rd;
						else begin
							op_q <= fh_pkg::OP_SUSPEND;
							{step_q, polling_q} <= '0;
						end
					end
				end
				fh_pkg::S_SUSP_WAIT: begin
					timer_q <= timer_q - 1'b1;
					if (timer_q == '0) begin
						susp_q <= 1'b1;
						finish(1'b0);
					end
				end
				default: state_q <= fh_pkg::S_IDLE;
			endcase
		end
	end

	// Bus is released on the same edge that oe drops, avoiding contention
	task automatic issue_read(input logic [20:0] a);
		fl_addr <= a[19:0];
		dq_out  <= {a[20], 15'h0000};
		dq_oe   <= idle_oe;
		{ce_n, oe_n} <= 2'h0;
		timer_q <= fh_pkg::ACC_CYC - 1'b1;
		state_q <= fh_pkg::S_READ;
	endtask : issue_read

	task automatic finish(input logic f);
		done_set_q <= 1'b1;
		fail_set_q <= f;
		{polling_q, last_read_q} <= 2'h0;
		state_q <= fh_pkg::S_IDLE;
	endtask : finish

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wait_cnt_q <= '0;
		else
			wait_cnt_q <= (state_q == fh_pkg::S_SUSP_WAIT) ? wait_cnt_q + 1'b1 : '0;
	end

	a_we_inside_ce: assert property (!we_n |-> !ce_n && oe_n)
		else $error("write strobe low outside chip select");
	a_data_at_rise: assert property ($rose(we_n) |-> $stable(dq_out) && !ce_n ##1 $stable(dq_out))
		else $error("write data not held across strobe rise");
	a_x8_upper_free: assert property (!byte_n |-> dq_oe[14:8] == 7'h00 && dq_oe[15])
		else $error("upper lines driven in x8 mode");
	a_prog_four_cycles: assert property ($rose(polling_q) && op_q == fh_pkg::OP_PROGRAM |-> step_q == 3'h4)
		else $error("program launched without four bus cycles");
	a_sector_code: assert property ($rose(we_n) && op_q == fh_pkg::OP_SECTOR && step_q == 3'h5
		|-> dq_out[7:0] == fh_pkg::CMD_SECTOR && fl_addr == tgt_q[19:0])
		else $error("sector erase last cycle wrong");
	a_block_code: assert property ($rose(we_n) && op_q == fh_pkg::OP_BLOCK && step_q == 3'h5
		|-> dq_out[7:0] == fh_pkg::CMD_BLOCK && fl_addr == tgt_q[19:0])
		else $error("block erase last cycle wrong");
	a_chip_last: assert property ($rose(we_n) && op_q == fh_pkg::OP_CHIP && step_q == 3'h5
		|-> dq_out[7:0] == fh_pkg::CMD_CHIP && fl_addr == fh_pkg::CHIP_ADDR)
		else $error("chip erase last cycle wrong");
	a_suspend_latency: assert property ($rose(susp_q)
		|-> $past(wait_cnt_q) == fh_pkg::SUSPEND_LATENCY_CYC - 1'b1)
		else $error("suspend wait not the full latency");
	a_resume_code: assert property ($rose(we_n) && op_q == fh_pkg::OP_RESUME
		|-> dq_out[7:0] == fh_pkg::CMD_RESUME ##1 !susp_q [*2])
		else $error("resume cycle wrong");
	a_fail_after_rereads: assert property (fail_set_q |-> vcnt_q == 2'h2 && done_set_q)
		else $error("failure reported before two rereads");

	c_program_done: cover property (op_q == fh_pkg::OP_PROGRAM && done_set_q && !fail_set_q);
	c_suspend_entered: cover property ($rose(susp_q));
	c_chip_erase_done: cover property (op_q == fh_pkg::OP_CHIP && done_set_q);
	c_status_fail: cover property (fail_set_q);
endmodule : flash_host_ctrl
`default_nettype wire

// file: common/fh_pkg.sv
// Constants for the host-side sequencer of a dual-bank parallel NOR flash.
// Assumes a 100 MHz system clock; all pin timing is derived from it.
package fh_pkg;
	localparam int CLK_PERIOD_NS      = 10;
	localparam int ADDR_SETUP_NS      = 20;
	localparam int WE_LOW_NS          = 40;
	localparam int READ_ACCESS_NS     = 70;
	localparam int SUSPEND_LATENCY_US = 10;
	localparam int TW                 = 11;
	// Least times round up to whole cycles
	localparam logic [TW-1:0] SETUP_CYC = TW'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TW-1:0] WE_CYC    = TW'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TW-1:0] ACC_CYC   = TW'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TW-1:0] SUSPEND_LATENCY_CYC =
		TW'((SUSPEND_LATENCY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CONFIG = 8'h14;
	localparam int CTRL_GO      = 0;
	localparam int CTRL_OP_LSB  = 4;
	localparam int STS_BUSY     = 0;
	localparam int STS_DONE     = 1;
	localparam int STS_FAIL     = 2;
	localparam int STS_REFUSED  = 3;
	localparam int STS_SUSP     = 4;
	localparam int STS_RDY      = 5;
	localparam logic [1:0] CFG_RESET = 2'h1;

	localparam logic [2:0] OP_READ    = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_SECTOR  = 3'h2;
	localparam logic [2:0] OP_BLOCK   = 3'h3;
	localparam logic [2:0] OP_CHIP    = 3'h4;
	localparam logic [2:0] OP_SUSPEND = 3'h5;
	localparam logic [2:0] OP_RESUME  = 3'h6;
	localparam logic [2:0] PROG_STEPS  = 3'h4;
	localparam logic [2:0] ERASE_STEPS = 3'h6;

	localparam logic [7:0]  CMD_SECTOR  = 8'h50;
	localparam logic [7:0]  CMD_BLOCK   = 8'h30;
	localparam logic [7:0]  CMD_CHIP    = 8'h10;
	localparam logic [7:0]  CMD_SUSPEND = 8'hB0;
	localparam logic [7:0]  CMD_RESUME  = 8'h30;
	localparam logic [19:0] CHIP_ADDR   = 20'h00555;
	localparam int SECTOR_LSB = 11;
	localparam int BLOCK_LSB  = 15;
	localparam logic [15:0] DQ_ALL    = 16'hFFFF;
	localparam logic [15:0] DQ_LOW_A1 = 16'h80FF;
	localparam logic [15:0] DQ_A1     = 16'h8000;

	typedef enum logic [2:0] {S_IDLE, S_GAP, S_SETUP, S_STROBE, S_HOLD, S_READ, S_SUSP_WAIT} state_t;
endpackage : fh_pkg

// file: verification/flash_model.sv
// Behavioural dual-bank parallel NOR flash: unlock sequences, program, erase, suspend, status bits.
// Assumes the bench resolves the shared data bus and pulls the ready/busy line up.
`timescale 1ns/1ns
`default_nettype none
module flash_model #(
	parameter int PROG_NS  = 7000,
	parameter int ERASE_NS = 20000,
	parameter int SUSP_NS  = 3000,
	parameter int ACC_NS   = 60
) (
	input  wire logic [19:0] fl_addr,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        byte_n,
	input  wire logic        wp_n,
	input  wire logic [15:0] dq,
	output var  logic [15:0] fdq,
	output var  logic [15:0] fdq_en,
	output var  logic        rb_low
);
	bit   [15:0] mem [0:20'hFFFFF];
	int          pl = 0, el = 0, step = 0, emode = 0;
	logic [19:0] wa, pa, ea;
	logic [15:0] pm;
	logic        wl, pb7, susp = 1'b0, tog = 1'b0;

	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	initial fdq = 16'h0000;

	function automatic logic in_area(input logic [19:0] a);
		return emode == 1 ? a[19:11] == ea[19:11] : emode == 2 ? a[19:15] == ea[19:15] : 1'b1;
	endfunction : in_area

	function automatic logic [15:0] rdv(input logic [19:0] a, input logic ln);
		logic [15:0] x;
		x = byte_n ? mem[a] : {8'h00, ln ? mem[a][15:8] : mem[a][7:0]};
		if (pl > 0 && a[19] == pa[19]) begin
			x[7] = ~pb7;
			x[6] = tog;
		end else if (el > 0 && !susp && (emode == 3 || a[19] == ea[19])) begin
			x[7] = 1'b0;
			x[6] = tog;
			x[2] = tog;
		end else if (susp && in_area(a)) begin
			x[7] = 1'b1;
			x[6] = 1'b1;
			x[2] = tog;
		end
		return x;
	endfunction : rdv

	// Output only while selected and gated; x8 leaves the upper lines floating
	assign fdq_en = (!ce_n && !oe_n) ? (byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
	// Stale data is inverted until the access time runs out, so an early sample cannot pass
	always @(negedge oe_n) begin
		fdq = ~fdq;
		#ACC_NS;
		fdq = rdv(fl_addr, dq[15]);
		tog = ~tog;
	end

	always @(negedge we_n) if (!ce_n) begin
		wa = fl_addr;
		wl = dq[15];
	end
	always @(posedge we_n) if (!ce_n) command(dq);

	task automatic command(input logic [15:0] d);
		logic [7:0] c;
		c = d[7:0];
		if (pl > 0 || (el > 0 && emode == 3)) return;
		if (el > 0 && !susp) begin
			if (c == 8'hB0) fork
				#SUSP_NS susp = el > 0;
			join_none
			return;
		end
		if (step == 6) begin
			step = 0;
			if (susp && in_area(wa)) return;
			pa = wa;
			pb7 = d[7];
			pm = byte_n ? d : (wl ? {d[7:0], 8'hFF} : {8'hFF, d[7:0]});
			pl = PROG_NS / 10;
			return;
		end
		if (susp && step == 0 && c == 8'h30) begin
			susp = 1'b0;
			return;
		end
		case (step)
			0: step = (wa == 20'h00555 && c == 8'hAA) ? 1 : 0;
			1: step = (wa == 20'h002AA && c == 8'h55) ? 2 : 0;
			2: step = wa != 20'h00555 ? 0 : c == 8'hA0 ? 6 : c == 8'h80 ? 3 : 0;
			3: step = (wa == 20'h00555 && c == 8'hAA) ? 4 : 0;
			4: step = (wa == 20'h002AA && c == 8'h55) ? 5 : 0;
			default: begin
				step = 0;
				if (!susp) begin
					emode = c == 8'h50 ? 1 : c == 8'h30 ? 2 : (c == 8'h10 && wa == 20'h00555 && wp_n) ? 3 : 0;
					ea = wa;
					if (emode != 0) el = ERASE_NS / 10;
				end
			end
		endcase
	endtask : command

	always #10 begin
		if (pl > 0) begin
			pl = pl - 1;
			if (pl == 0) mem[pa] = mem[pa] & pm;
		end
		if (el > 0 && !susp) begin
			el = el - 1;
			if (el == 0) for (int i = 0; i < 1048576; i++) if (in_area(20'(i))) mem[i] = 16'hFFFF;
		end
	end
	assign rb_low = pl > 0 || (el > 0 && !susp);
endmodule : flash_model
`default_nettype wire

// file: verification/dual_bank_parallel_flash_ops_tb.sv
// Self-checking bench: AHB-Lite register master, flash model, random programs and erase corners.
// Assumes the controller answers with zero wait states and polls the flash until done.
`timescale 1ns/1ns
`default_nettype none
module dual_bank_parallel_flash_ops_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, x8 = 1'b0, sus = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, ce_n, we_n, oe_n, byte_n, wp_n, rb_low;
	logic [19:0] fl_addr;
	logic [15:0] dq_out, dq_oe, fdq, fdq_en, junk = 16'h5A5A;
	wire  [15:0] dq;
	wire         ready_busy_n;
	int          n_fail = 0, samples_checked = 0, seed = 32'h14DA;
	bit   [15:0] em [0:20'hFFFFF];

	// Released lines never hold their last value; the pull-up sets ready when nobody pulls
	assign dq = (dq_oe & dq_out) | (~dq_oe & fdq_en & fdq) | (~dq_oe & ~fdq_en & junk);
	assign ready_busy_n = ~rb_low;

	flash_host_ctrl i_flash_host_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_addr(fl_addr), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .byte_n(byte_n), .wp_n(wp_n), .dq_in(dq), .dq_out(dq_out),
		.dq_oe(dq_oe), .ready_busy_n(ready_busy_n));
	flash_model i_flash_model (.fl_addr(fl_addr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.byte_n(byte_n), .wp_n(wp_n), .dq(dq), .fdq(fdq), .fdq_en(fdq_en), .rb_low(rb_low));

	initial forever #5 hclk = ~hclk;
	always @(posedge hclk) junk <= ~junk;
	initial foreach (em[i]) em[i] = 16'hFFFF;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t ns: seen %08h expected %08h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
		rd = hrdata;
		if (n >= 50)
			n_fail++;
	endtask : ahb

	task automatic start(input logic [2:0] code, input logic [20:0] a, input logic [15:0] d);
		ahb(1'b1, fh_pkg::REG_STATUS, 32'h0000000E);
		ahb(1'b1, fh_pkg::REG_WDATA, {16'h0, d});
		ahb(1'b1, fh_pkg::REG_ADDR, {11'h0, a});
		ahb(1'b1, fh_pkg::REG_CTRL, {25'h0, code, 4'h1});
	endtask : start

	task automatic op(input logic [2:0] code, input logic [20:0] a, input logic [15:0] d);
		start(code, a, d);
		for (int n = 0; n < 4000; n++) begin
			ahb(1'b0, fh_pkg::REG_STATUS, 32'h0);
			if (rd[1] === 1'b1 || rd[3] === 1'b1) break;
		end
		// An operation that never ends counts as a mismatch
		if (rd[1] !== 1'b1 && rd[3] !== 1'b1)
			n_fail++;
	endtask : op

	function automatic logic [31:0] exp_rd(input logic [20:0] a);
		logic [15:0] w;
		w = em[a[19:0]];
		return x8 ? {24'h0, a[20] ? w[15:8] : w[7:0]} : {16'h0, w};
	endfunction : exp_rd

	task automatic prog(input logic [20:0] a, input logic [15:0] d);
		op(fh_pkg::OP_PROGRAM, a, d);
		check(rd & 32'h3F, {26'h0, 1'b1, sus, 4'h2});
		em[a[19:0]] = em[a[19:0]] & (!x8 ? d : a[20] ? {d[7:0], 8'hFF} : {8'hFF, d[7:0]});
	endtask : prog

	task automatic rdchk(input logic [20:0] a);
		op(fh_pkg::OP_READ, a, 16'h0);
		ahb(1'b0, fh_pkg::REG_RDATA, 32'h0);
		check(rd, exp_rd(a));
	endtask : rdchk

	task automatic erase(input logic [19:0] base, input int n);
		for (int k = 0; k < n; k++) em[base + 20'(k)] = 16'hFFFF;
	endtask : erase

	// Pin watch: no contention on reads, strobes only with the chip selected, A-1 driven in x8
	always @(posedge hclk) if (hresetn) begin
		if (!ce_n && !oe_n) check({16'h0, dq_oe & fdq_en}, 32'h0);
		if (!we_n) check({31'h0, ce_n | ~oe_n}, 32'h0);
		if (!byte_n && !ce_n) check({31'h0, dq_oe[15]}, 32'h1);
		check({30'h0, hresp, hreadyout}, 32'h1);
	end

	initial begin
		#600000;
		n_fail++;
		results();
	end

	initial begin
		logic [20:0] a;
		logic [15:0] d;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, fh_pkg::REG_CONFIG, 32'h0);
		check(rd, 32'h00000001);
		ahb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h00000000);
		ahb(1'b0, fh_pkg::REG_STATUS, 32'h0);
		check(rd & 32'h3F, 32'h20);
		op(fh_pkg::OP_CHIP, 21'h00555, 16'h0);
		check(rd & 32'h39, 32'h28);
		ahb(1'b1, fh_pkg::REG_CONFIG, 32'h3);
		op(fh_pkg::OP_CHIP, 21'h00555, 16'h0);
		check(rd & 32'h3F, 32'h22);
		erase(20'h0, 1048576);
		for (int i = 0; i < 8; i++) begin
			a = {1'b0, 20'($random(seed))};
			d = 16'($random(seed));
			prog(a, d);
			rdchk(a);
		end
		// Sector erase suspended and then resumed to completion, with traffic around the suspended sector
		prog(21'h01801, 16'h1234);
		start(fh_pkg::OP_SECTOR, 21'h01800, 16'h0);
		for (int n = 0; n < 100; n++) begin
			ahb(1'b0, fh_pkg::REG_STATUS, 32'h0);
			if (rd[5] === 1'b0) break;
		end
		check({31'h0, rd[5]}, 32'h0);
		op(fh_pkg::OP_SUSPEND, 21'h01800, 16'h0);
		check(rd & 32'h3F, 32'h32);
		sus = 1'b1;
		op(fh_pkg::OP_READ, 21'h01801, 16'h0);
		ahb(1'b0, fh_pkg::REG_RDATA, 32'h0);
		check(rd & 32'hC0, 32'hC0);
		prog(21'h02000, 16'($random(seed)));
		op(fh_pkg::OP_PROGRAM, 21'h01802, 16'h0);
		check(rd & 32'h39, 32'h38);
		sus = 1'b0;
		op(fh_pkg::OP_RESUME, 21'h01800, 16'h0);
		check(rd & 32'h3F, 32'h22);
		erase(20'h01800, 2048);
		rdchk(21'h01801);
		rdchk(21'h02000);
		prog(21'h08010, 16'h0F0F);
		op(fh_pkg::OP_BLOCK, 21'h08000, 16'h0);
		check(rd & 32'h3F, 32'h22);
		erase(20'h08000, 32768);
		rdchk(21'h08010);
		ahb(1'b1, fh_pkg::REG_CONFIG, 32'h2);
		x8 = 1'b1;
		a = {1'b1, 20'($random(seed))};
		prog(a, {8'h00, 8'($random(seed))});
		rdchk(a);
		rdchk({1'b0, a[19:0]});
		results();
	end
endmodule : dual_bank_parallel_flash_ops_tb
`default_nettype wire
